/* logic/hpim_pkg.sv */
// Contract
// - Mask-set write of one sets bit if implemented (31, 12, 11, 4, 0)
// - Mask-clear write of one clears bit
// - Set and clear both read current mask
// - Masked bit is source and mask
// - Processor output follows any masked bit
// - Second processor output follows masked bits
// - Fast output follows any masked bit
// - Register writes never clear any source except bit 31 test, which drops once mask-clear writes leave no test mask set
// - Mask clear removes source contribution at once
// - Bit 12 is firmware event
// - Bit 11 is access error
// - Bit 4 is motion sync vector
// - Bit 0 is comm channel vector
// - Bit 31 test follows any test mask
// - Raw bits 12, 11, 4 and 0 follow source regardless of masks
package hpim_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam int VEC_W = 16;

    localparam logic [31:0] CPU_IRQ_MASK_SET_ADDR = 32'h101C1284;
    localparam logic [31:0] CPU_IRQ_MASK_CLEAR_ADDR = 32'h101C1288;
    localparam logic [31:0] CPU_IRQ_MASKED_STATUS_ADDR = 32'h101C128C;
    localparam logic [31:0] AUX_CPU_IRQ_MASK_SET_ADDR = 32'h101C1290;
    localparam logic [31:0] AUX_CPU_IRQ_MASK_CLEAR_ADDR = 32'h101C1294;
    localparam logic [31:0] AUX_CPU_IRQ_MASKED_STATUS_ADDR = 32'h101C1298;
    localparam logic [31:0] FAST_IRQ_MASK_SET_ADDR = 32'h101C129C;
    localparam logic [31:0] FAST_IRQ_MASK_CLEAR_ADDR = 32'h101C12A0;
    localparam logic [31:0] FAST_IRQ_MASKED_STATUS_ADDR = 32'h101C12A4;

    localparam int BIT_TEST = 31;
    localparam int BIT_FIRMWARE = 12;
    localparam int BIT_ACCESS_ERR = 11;
    localparam int BIT_MOTION_SYNC = 4;
    localparam int BIT_COMM = 0;

    localparam int MSYNC_VEC_HI = 15;
    localparam int MSYNC_VEC_LO = 12;
    localparam int COMM_VEC_HI = 11;
    localparam int COMM_VEC_LO = 0;

    localparam logic [31:0] IMPL_BITS = 32'h80001811;
    localparam logic [31:0] MASK_RESET = 32'h00000000;
    localparam logic [31:0] RDATA_RESET = 32'h00000000;
endpackage

/* logic/hpim_mask_if.sv */
`timescale 1ns/1ps
interface hpim_mask_if #(parameter int WIDTH = 32);
    logic wr_set;
    logic wr_clear;
    logic [WIDTH-1:0] wdata;
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] mask;
    logic [WIDTH-1:0] masked;
    modport ctrl (output wr_set, output wr_clear, output wdata, output raw, input mask, input masked);
    modport regs (input wr_set, input wr_clear, input wdata, input raw, output mask, output masked);
endinterface

/* logic/hpim_mask_pair.sv */
`timescale 1ns/1ps
module hpim_mask_pair
    import hpim_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    hpim_mask_if.regs port_if
);
    logic [DATA_W-1:0] mask;
    logic [DATA_W-1:0] set_bits;
    logic [DATA_W-1:0] clear_bits;
    logic [DATA_W-1:0] next_mask;

    assign set_bits = port_if.wr_set ? (port_if.wdata & IMPL_BITS) : MASK_RESET;
    assign clear_bits = port_if.wr_clear ? port_if.wdata : MASK_RESET;
    assign next_mask = ((mask | set_bits) & ~clear_bits) & IMPL_BITS;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mask <= MASK_RESET;
        end else begin
            mask <= next_mask;
        end
    end

    assign port_if.mask = mask;
    assign port_if.masked = port_if.raw & mask;
endmodule

/* logic/hpim_irq_route.sv */
// The strobed register port was decided locally.
`timescale 1ns/1ps
module hpim_irq_route
    import hpim_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic firmware_irq_i,
    input wire logic access_err_irq_i,
    input wire logic [VEC_W-1:0] protocol_engine_irq_vector_i,
    output logic [DATA_W-1:0] rdata_o,
    output logic cpu_irq_o,
    output logic aux_cpu_irq_o,
    output logic fast_interrupt_o
);
    hpim_mask_if #(.WIDTH(DATA_W)) cpu_if ();
    hpim_mask_if #(.WIDTH(DATA_W)) aux_if ();
    hpim_mask_if #(.WIDTH(DATA_W)) fast_if ();

    logic [DATA_W-1:0] raw_status;
    logic [DATA_W-1:0] next_rdata;
    logic test_raw;
    logic motion_sync_channel;
    logic comm_channel;

    assign motion_sync_channel = |protocol_engine_irq_vector_i[MSYNC_VEC_HI:MSYNC_VEC_LO];
    assign comm_channel = |protocol_engine_irq_vector_i[COMM_VEC_HI:COMM_VEC_LO];
    assign test_raw = cpu_if.mask[BIT_TEST] | aux_if.mask[BIT_TEST] | fast_if.mask[BIT_TEST];

    always_comb begin
        raw_status = '0;
        raw_status[BIT_TEST] = test_raw;
        raw_status[BIT_FIRMWARE] = firmware_irq_i;
        raw_status[BIT_ACCESS_ERR] = access_err_irq_i;
        raw_status[BIT_MOTION_SYNC] = motion_sync_channel;
        raw_status[BIT_COMM] = comm_channel;
    end

    assign cpu_if.raw = raw_status;
    assign aux_if.raw = raw_status;
    assign fast_if.raw = raw_status;

    assign cpu_if.wdata = wdata_i;
    assign aux_if.wdata = wdata_i;
    assign fast_if.wdata = wdata_i;

    assign cpu_if.wr_set = wr_i && (addr_i == CPU_IRQ_MASK_SET_ADDR);
    assign aux_if.wr_set = wr_i && (addr_i == AUX_CPU_IRQ_MASK_SET_ADDR);
    assign fast_if.wr_set = wr_i && (addr_i == FAST_IRQ_MASK_SET_ADDR);
    assign cpu_if.wr_clear = wr_i && (addr_i == CPU_IRQ_MASK_CLEAR_ADDR);
    assign aux_if.wr_clear = wr_i && (addr_i == AUX_CPU_IRQ_MASK_CLEAR_ADDR);
    assign fast_if.wr_clear = wr_i && (addr_i == FAST_IRQ_MASK_CLEAR_ADDR);

    hpim_mask_pair u_cpu_mask (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .port_if(cpu_if.regs)
    );

    hpim_mask_pair u_aux_mask (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .port_if(aux_if.regs)
    );

    hpim_mask_pair u_fast_mask (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .port_if(fast_if.regs)
    );

    always_comb begin
        unique case (addr_i)
            CPU_IRQ_MASK_SET_ADDR, CPU_IRQ_MASK_CLEAR_ADDR: next_rdata = cpu_if.mask;
            CPU_IRQ_MASKED_STATUS_ADDR: next_rdata = cpu_if.masked;
            AUX_CPU_IRQ_MASK_SET_ADDR, AUX_CPU_IRQ_MASK_CLEAR_ADDR: next_rdata = aux_if.mask;
            AUX_CPU_IRQ_MASKED_STATUS_ADDR: next_rdata = aux_if.masked;
            FAST_IRQ_MASK_SET_ADDR, FAST_IRQ_MASK_CLEAR_ADDR: next_rdata = fast_if.mask;
            FAST_IRQ_MASKED_STATUS_ADDR: next_rdata = fast_if.masked;
            default: next_rdata = RDATA_RESET;
        endcase
    end

    // Read data held one cycle after strobe
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= RDATA_RESET;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= RDATA_RESET;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cpu_irq_o <= 1'b0;
            aux_cpu_irq_o <= 1'b0;
            fast_interrupt_o <= 1'b0;
        end else begin
            cpu_irq_o <= |cpu_if.masked;
            aux_cpu_irq_o <= |aux_if.masked;
            fast_interrupt_o <= |fast_if.masked;
        end
    end
endmodule

/* sim/hpim_checker.sv */
`timescale 1ns/1ps
module hpim_chk import hpim_pkg::*; (
    input logic clock_i,
    input logic rst_n_i,
    input logic [ADDR_W-1:0] addr_i,
    input logic rd_i,
    input logic firmware_irq_i,
    input logic access_err_irq_i,
    input logic [VEC_W-1:0] protocol_engine_irq_vector_i,
    input logic [DATA_W-1:0] rdata_o,
    input logic cpu_irq_o,
    input logic aux_cpu_irq_o,
    input logic fast_interrupt_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    wire rc = rd_i && addr_i == CPU_IRQ_MASKED_STATUS_ADDR;
    wire ra = rd_i && addr_i == AUX_CPU_IRQ_MASKED_STATUS_ADDR;
    wire rf = rd_i && addr_i == FAST_IRQ_MASKED_STATUS_ADDR;
    AST_RES: assert property ((rdata_o & ~IMPL_BITS) == 0) else $error("rsv");
    AST_CPU: assert property (rc |=> cpu_irq_o == |rdata_o) else $error("cpu");
    AST_AUX: assert property (ra |=> aux_cpu_irq_o == |rdata_o) else $error("aux");
    AST_FST: assert property (rf |=> fast_interrupt_o == |rdata_o) else $error("fst");
    AST_FW: assert property (rc && !firmware_irq_i |=> !rdata_o[BIT_FIRMWARE]) else $error("fw");
    AST_ERR: assert property (rc && !access_err_irq_i |=> !rdata_o[BIT_ACCESS_ERR]) else $error("err");
    AST_MS: assert property (rc && protocol_engine_irq_vector_i[MSYNC_VEC_HI:MSYNC_VEC_LO] == 0 |=>
        !rdata_o[BIT_MOTION_SYNC]) else $error("ms");
    AST_COM: assert property (rc && protocol_engine_irq_vector_i[COMM_VEC_HI:COMM_VEC_LO] == 0 |=>
        !rdata_o[BIT_COMM]) else $error("com");
endmodule
bind hpim_irq_route hpim_chk u_chk(.*);

/* sim/hpim_src_model.sv */
`timescale 1ns/1ps
module hpim_src_model (
    input logic clock_i,
    input logic [17:0] req_i,
    output logic [17:0] src_o
);
    always_ff @(posedge clock_i) src_o <= req_i;
endmodule

/* sim/hpim_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench import hpim_pkg::*; ;
    logic clock_i = '0, rst_n_i = '0, wr_i = '0, rd_i = '0;
    logic [31:0] addr_i = '0, wdata_i = '0, rdata_o;
    logic cpu_irq_o, aux_cpu_irq_o, fast_interrupt_o;
    logic [17:0] req_i = '0, s;
    int fails = 0, checked = 0;
    always #5 clock_i = ~clock_i;
    hpim_src_model u_src(.clock_i, .req_i, .src_o(s));
    hpim_irq_route u_dut(.*, .firmware_irq_i(s[17]), .access_err_irq_i(s[16]),
        .protocol_engine_irq_vector_i(s[15:0]));
    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge clock_i);
        {wr_i, rd_i, addr_i, wdata_i} <= {w, !w, a, d};
        @(posedge clock_i);
        {wr_i, rd_i} <= 2'b00;
        #1 if (!w) `CHK("rdata", d, rdata_o)
    endtask
    task automatic t_regs;
        for (int p = 0; p < 3; p++) begin
            logic [31:0] b = CPU_IRQ_MASK_SET_ADDR + 12 * p;
            bus(0, b + 8, '0);
            bus(1, b, '1);
            bus(0, b + 4, IMPL_BITS);
            bus(1, b + 4, 32'h00001001);
            bus(1, b, '0);
            bus(0, b, 32'h80000810);
            bus(1, b + 4, '1);
        end
        bus(0, 32'h101C1280, '0);
        $display("regs");
    endtask
    task automatic t_route;
        logic [17:0] v [5] = '{18'h20000, 18'h10000, 18'h08000, 18'h00001, 18'h00000};
        int bt [5] = '{12, 11, 4, 0, 31};
        for (int i = 0; i < 5; i++) begin
            logic [31:0] b = CPU_IRQ_MASK_SET_ADDR + 12 * (i % 3);
            logic [2:0] hot = 3'b100 >> (i % 3);
            @(posedge clock_i) req_i <= v[i];
            bus(1, b, 32'h1 << bt[i]);
            bus(0, b + 8, 32'h1 << bt[i]);
            `CHK("irq", hot, {cpu_irq_o, aux_cpu_irq_o, fast_interrupt_o})
            bus(1, b + 4, '1);
            bus(0, b + 8, '0);
            `CHK("irq", 3'b000, {cpu_irq_o, aux_cpu_irq_o, fast_interrupt_o})
            bus(1, b, 32'h1 << bt[i]);
            bus(0, b + 8, 32'h1 << bt[i]);
            bus(1, b + 4, '1);
        end
        $display("route");
    endtask
    task automatic print_verdict;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_regs;
        t_route;
        print_verdict;
    end
    initial begin
        #9000;
        fails++;
        print_verdict;
    end
endmodule
